// ---- common/eisb_pkg.sv ----
// Purpose: Constants and carrier types for the serial EEPROM slave bus front end.
// Assumes: Core clock of 100 MHz; the bus clock line is the link clock domain.
// Notes: All timing counts are derived from times in their printed units.
//
// What this block does
// - Leave reset into standby above trigger level.
// - Supply drop forces reset mode.
// - Ready for commands within 1 ms.
// - Filter glitches up to 100 ns.
// - Data pin only pulled low or released.
// - Sample on rising, change after falling edge.
// - Slave only; never drives clock line.
// - Zero pulls low, one releases line.
// - Data held stable while clock high.
// - START is data fall with clock high.
// - Ignore everything until a START.
// - STOP is data rise, ends command.
// - First four address bits must be 1010.
// - Next three bits match strap pins, MSB first.
// - Pinless packages answer only address zero.
// - Eighth bit one reads, zero writes.
// - Address pins are static straps, eight devices.
// - Floating straps and protect read low.
// - Protect high refuses array writes.
// - Package without protect pin accepts writes.
// - Ninth clock carries acknowledge or not.
// - During write cycle release line, no acknowledge.
// - Protect sampled before first data refuses it.
package eisb_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_MHZ = 100;         // Core clock rate
  localparam int GLITCH_NS = 100;            // Widest pulse to reject
  localparam int GLITCH_CYC = (GLITCH_NS * CORE_CLK_MHZ + 999) / 1000 + 1;
  localparam int POWERUP_MS = 1;             // Power-up to ready
  localparam int POWERUP_CYC = POWERUP_MS * CORE_CLK_MHZ * 1000;
  localparam int WRITE_MS = 5;               // Internal write duration
  localparam int WRITE_CYC = WRITE_MS * CORE_CLK_MHZ * 1000;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE = 4'ha;    // Fixed device-type pattern
  localparam logic [2:0] PINLESS_ADDR = 3'h0; // Address of pinless parts
  localparam logic RW_READ = 1'h1;           // Direction bit meaning read
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h8;    // Ninth clock index

  // Frame phase of the link side
  typedef enum logic [2:0] {
    EISB_IDLE = 3'b000,   // Waiting for START
    EISB_ADDR = 3'b001,   // Shifting address byte
    EISB_ADDR_ACK = 3'b010,
    EISB_WDATA = 3'b011,  // Receiving write bytes
    EISB_WACK = 3'b100,
    EISB_RDATA = 3'b101,  // Sending read bytes
    EISB_RACK = 3'b110,   // Master answers read byte
    EISB_SKIP = 3'b111    // Not selected, wait for STOP
  } eisb_state_e;

  // Filtered bus levels handed to the link side
  typedef struct packed {
    logic scl;
    logic sda;
  } eisb_bus_s;

  // Received-byte strobe toward the core
  typedef struct packed {
    logic [7:0] data;
    logic is_write;
  } eisb_byte_s;

endpackage

// ---- logic/eisb_front.sv ----
// Purpose: Slave bus front end: filtering, START/STOP, address match, ack.
// Assumes: Bus lines arrive asynchronously; straps are static after reset.
// Notes: Bus logic runs on the filtered bus clock as its own domain.
`timescale 1ns/1ps
module eisb_front #(
  parameter int POWERUP_CYCLES = eisb_pkg::POWERUP_CYC,
  parameter int WRITE_CYCLES = eisb_pkg::WRITE_CYC,
  parameter bit HAS_ADDR_PINS = 1'b1,   // Pinless packages set zero
  parameter bit HAS_WP_PIN = 1'b1       // Four-ball package sets zero
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,            // Supply monitor reset, low active
  input wire logic CLK_EN_I,
  input wire logic SCL_I,               // Bus clock level
  input wire logic SDA_I,               // Bus data level
  input wire logic [2:0] ADDR_STRAP_I,  // Strap pins, already pulled low
  input wire logic WP_I,                // Write protect, pulled low
  input wire logic RD_DATA_VALID_I,     // Unused for now: read data strobe
  input wire logic [7:0] RD_DATA_I,     // Byte to send on reads
  output logic SDA_O,                   // Always low when enabled
  output logic SDA_OE_O,                // High while pulling data low
  output logic READY_O,                 // Power-up delay finished
  output logic WRITE_BUSY_O,            // Internal write in progress
  output logic BYTE_STB_O,              // One-cycle pulse per write byte
  output logic [7:0] BYTE_DATA_O,
  output logic FRAME_END_O              // One-cycle pulse on STOP
);

  initial begin
    if (POWERUP_CYCLES < 1 || WRITE_CYCLES < 1) begin
      $error("Cycle counts must be at least one");
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers and glitch filters
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_r, sda_sync_r;  // Two-flop chains
  logic [1:0] wp_sync_r;
  logic [7:0] flt_cnt_scl_r, flt_cnt_sda_r;
  eisb_pkg::eisb_bus_s flt_r;          // Filtered levels

  // Two-flop capture before anything reads the pins
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      wp_sync_r <= 2'h0;
    end else if (CLK_EN_I) begin
      scl_sync_r <= {scl_sync_r[0], SCL_I};
      sda_sync_r <= {sda_sync_r[0], SDA_I};
      wp_sync_r <= {wp_sync_r[0], WP_I};
    end
  end

  // A level must persist beyond the glitch width before it is accepted;
  // this adds about 110 ns latency, well inside the low clock phase
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flt_cnt_scl_r <= 8'h0;
      flt_cnt_sda_r <= 8'h0;
      flt_r <= '{scl: 1'b1, sda: 1'b1};
    end else if (CLK_EN_I) begin
      if (scl_sync_r[1] == flt_r.scl) begin
        flt_cnt_scl_r <= 8'h0;
      end else if (flt_cnt_scl_r == 8'(eisb_pkg::GLITCH_CYC - 1)) begin
        flt_r.scl <= scl_sync_r[1];
        flt_cnt_scl_r <= 8'h0;
      end else begin
        flt_cnt_scl_r <= flt_cnt_scl_r + 8'h1;
      end
      if (sda_sync_r[1] == flt_r.sda) begin
        flt_cnt_sda_r <= 8'h0;
      end else if (flt_cnt_sda_r == 8'(eisb_pkg::GLITCH_CYC - 1)) begin
        flt_r.sda <= sda_sync_r[1];
        flt_cnt_sda_r <= 8'h0;
      end else begin
        flt_cnt_sda_r <= flt_cnt_sda_r + 8'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-up and write-cycle timers
  // ----------------------------------------------------------------
  logic [31:0] pu_cnt_r;      // Counts toward ready
  logic ready_r;
  logic [31:0] wr_cnt_r;      // Internal write countdown
  logic wr_busy_r;
  logic [2:0] strap_r;        // Strap levels after the two-flop chain
  logic [2:0] strap_s1_r, strap_s2_r;  // Two-flop chain on the strap pins

  // Reset mode is the supply monitor holding RESETN_I low
  // Standby is reached after the power-up delay
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pu_cnt_r <= 32'h0;
      ready_r <= 1'b0;
    end else if (CLK_EN_I && !ready_r) begin
      if (pu_cnt_r == 32'(POWERUP_CYCLES - 1)) begin
        ready_r <= 1'b1;
      end else begin
        pu_cnt_r <= pu_cnt_r + 32'h1;
      end
    end
  end

  // Straps pass two flops like any pin; they are static by design
  // Tracking them all the time costs nothing, since they never move
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
      strap_r <= 3'h0;
    end else if (CLK_EN_I) begin
      strap_s1_r <= ADDR_STRAP_I;
      strap_s2_r <= strap_s1_r;
      // Pinless parts behave as all-zero straps
      strap_r <= HAS_ADDR_PINS ? strap_s2_r : eisb_pkg::PINLESS_ADDR;
    end
  end

  // ----------------------------------------------------------------
  // Link domain on the filtered bus clock
  // ----------------------------------------------------------------
  logic bus_clk;              // Filtered clock, clocks the link logic
  logic sda_f;
  logic start_seen, stop_seen;
  logic sda_prev_r;           // Core-side edge detect of data
  assign bus_clk = flt_r.scl;
  assign sda_f = flt_r.sda;

  // START/STOP live in the core domain: data edges with clock high
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      sda_prev_r <= 1'b1;
    end else if (CLK_EN_I) begin
      sda_prev_r <= sda_f;
    end
  end
  assign start_seen = CLK_EN_I && ready_r && bus_clk && sda_prev_r && !sda_f;
  assign stop_seen = CLK_EN_I && bus_clk && !sda_prev_r && sda_f;

  // Toggles carry START/STOP into the link domain
  logic start_tgl_r, stop_tgl_r;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      start_tgl_r <= 1'b0;
      stop_tgl_r <= 1'b0;
    end else begin
      if (start_seen) start_tgl_r <= ~start_tgl_r;
      if (stop_seen) stop_tgl_r <= ~stop_tgl_r;
    end
  end

  // Link state; bus clock stands still between frames, so a START is
  // recognised on the first rising edge after it, which also samples the first address bit
  eisb_pkg::eisb_state_e st_r;
  logic start_ack_r, stop_ack_r;     // Last toggle values seen
  logic [7:0] shift_r;
  logic [3:0] bit_r;
  logic first_data_r, wp_hit_r, ack_now_r;
  logic byte_tgl_r;                  // Event toggle toward core
  logic [7:0] byte_r;
  logic busy_l1_r, busy_l2_r;        // Write busy into link domain
  logic wp_l1_r, wp_l2_r;            // Protect level into link domain
  logic new_start, new_stop;
  assign new_start = start_tgl_r != start_ack_r;
  assign new_stop = stop_tgl_r != stop_ack_r;

  // Level crossings into the link domain
  always_ff @(posedge bus_clk or negedge RESETN_I) begin
    if (!RESETN_I) begin
      busy_l1_r <= 1'b0;
      busy_l2_r <= 1'b0;
      wp_l1_r <= 1'b0;
      wp_l2_r <= 1'b0;
    end else begin
      busy_l1_r <= wr_busy_r;
      busy_l2_r <= busy_l1_r;
      wp_l1_r <= wp_sync_r[1];
      wp_l2_r <= wp_l1_r;
    end
  end

  // Rising edge: sample data, advance the byte machine
  always_ff @(posedge bus_clk or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_r <= eisb_pkg::EISB_IDLE;
      start_ack_r <= 1'b0;
      stop_ack_r <= 1'b0;
      shift_r <= 8'h0;
      bit_r <= 4'h0;
      first_data_r <= 1'b0;
      wp_hit_r <= 1'b0;
      byte_tgl_r <= 1'b0;
      byte_r <= 8'h0;
    end else begin
      start_ack_r <= start_tgl_r;
      stop_ack_r <= stop_tgl_r;
      if (new_start) begin
        // Restart counts the edge as the first address bit
        st_r <= eisb_pkg::EISB_ADDR;
        shift_r <= {7'h0, sda_f};
        bit_r <= 4'h1;
      end else if (new_stop) begin
        st_r <= eisb_pkg::EISB_IDLE;
      end else begin
        case (st_r)
          eisb_pkg::EISB_ADDR, eisb_pkg::EISB_WDATA: begin
            shift_r <= {shift_r[6:0], sda_f};
            bit_r <= bit_r + 4'h1;
            if (bit_r == eisb_pkg::ACK_SLOT - 4'h1) begin
              st_r <= (st_r == eisb_pkg::EISB_ADDR) ? eisb_pkg::EISB_ADDR_ACK
                                                    : eisb_pkg::EISB_WACK;
            end
          end
          eisb_pkg::EISB_ADDR_ACK: begin
            bit_r <= 4'h0;
            first_data_r <= 1'b1;
            if (!ack_now_r) begin
              st_r <= eisb_pkg::EISB_SKIP;
            end else if (shift_r[0] == eisb_pkg::RW_READ) begin
              st_r <= eisb_pkg::EISB_RDATA;
            end else begin
              st_r <= eisb_pkg::EISB_WDATA;
            end
          end
          eisb_pkg::EISB_WACK: begin
            bit_r <= 4'h0;
            first_data_r <= 1'b0;
            if (!ack_now_r) begin
              st_r <= eisb_pkg::EISB_SKIP;    // Refused write
            end else begin
              st_r <= eisb_pkg::EISB_WDATA;
              byte_r <= shift_r;
              byte_tgl_r <= ~byte_tgl_r;
            end
          end
          eisb_pkg::EISB_RDATA: begin
            bit_r <= bit_r + 4'h1;
            if (bit_r == eisb_pkg::ACK_SLOT - 4'h1) st_r <= eisb_pkg::EISB_RACK;
          end
          eisb_pkg::EISB_RACK: begin
            bit_r <= 4'h0;
            // Master's not_acknowledged ends sending
            st_r <= sda_f ? eisb_pkg::EISB_SKIP : eisb_pkg::EISB_RDATA;
          end
          eisb_pkg::EISB_SKIP, eisb_pkg::EISB_IDLE: begin
            st_r <= st_r;                 // Wait for START or STOP
          end
          default: st_r <= eisb_pkg::EISB_IDLE;
        endcase
      end
      // Protect sampled on the edge before the first data byte
      if (st_r == eisb_pkg::EISB_ADDR_ACK) wp_hit_r <= HAS_WP_PIN && wp_l2_r;
    end
  end

  // Falling edge: set the data pin drive for the next high phase
  // The drive request is a falling-edge flop of its own: decoding it from
  // the state would move the data line right after a rising edge, while
  // the bus clock is still high, and drop the ack before the master looks
  logic [7:0] tx_r;
  logic drive_low;                   // Pull request for the coming high phase
  logic addr_match, data_ok;
  // Type, strap and busy checks decide the address ack
  assign addr_match = shift_r[7:4] == eisb_pkg::DEV_TYPE
                   && shift_r[3:1] == strap_r
                   && !busy_l2_r;
  // First data byte refused under protect
  assign data_ok = !(first_data_r && wp_hit_r);
  always_ff @(negedge bus_clk or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ack_now_r <= 1'b0;
      drive_low <= 1'b0;
      tx_r <= 8'hff;
    end else begin
      ack_now_r <= 1'b0;
      drive_low <= 1'b0;             // Released unless a branch pulls
      case (st_r)
        eisb_pkg::EISB_ADDR_ACK: begin
          ack_now_r <= addr_match;
          drive_low <= addr_match;   // Ninth clock answer
          tx_r <= RD_DATA_I;
        end
        eisb_pkg::EISB_WACK: begin
          ack_now_r <= data_ok;
          drive_low <= data_ok;      // Ninth clock answer
        end
        eisb_pkg::EISB_RDATA: begin
          // Zero read bits pull, ones release, most significant first
          if (bit_r != 4'h0) begin
            tx_r <= {tx_r[6:0], 1'b1};
            drive_low <= !tx_r[6];
          end else begin
            drive_low <= !tx_r[7];
          end
        end
        // Line released so the master can answer the read byte
        eisb_pkg::EISB_RACK: tx_r <= RD_DATA_I;
        default: ack_now_r <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Core-side outputs
  // ----------------------------------------------------------------
  logic [1:0] drv_sync_r, btgl_sync_r;
  logic btgl_prev_r;
  logic [7:0] byte_hold_r;

  // Bring drive request and byte events back to the core clock
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      drv_sync_r <= 2'h0;
      btgl_sync_r <= 2'h0;
      btgl_prev_r <= 1'b0;
      byte_hold_r <= 8'h0;
    end else if (CLK_EN_I) begin
      drv_sync_r <= {drv_sync_r[0], drive_low};
      btgl_sync_r <= {btgl_sync_r[0], byte_tgl_r};
      btgl_prev_r <= btgl_sync_r[1];
      byte_hold_r <= byte_r;   // Stable for many core cycles after toggle
    end
  end

  // Pin drive: only ever low, never high; clock line never driven
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      SDA_O <= 1'b0;
      SDA_OE_O <= 1'b0;
      READY_O <= 1'b0;
      WRITE_BUSY_O <= 1'b0;
      BYTE_STB_O <= 1'b0;
      BYTE_DATA_O <= 8'h0;
      FRAME_END_O <= 1'b0;
    end else if (CLK_EN_I) begin
      SDA_O <= 1'b0;
      SDA_OE_O <= drv_sync_r[1] && !wr_busy_r;
      READY_O <= ready_r;
      WRITE_BUSY_O <= wr_busy_r;
      BYTE_STB_O <= btgl_sync_r[1] != btgl_prev_r;
      BYTE_DATA_O <= byte_hold_r;
      FRAME_END_O <= stop_seen;
    end
  end

  // Write cycle starts on STOP after accepted write bytes
  logic wrote_r;
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wrote_r <= 1'b0;
      wr_busy_r <= 1'b0;
      wr_cnt_r <= 32'h0;
    end else if (CLK_EN_I) begin
      if (start_seen) wrote_r <= 1'b0;
      if (btgl_sync_r[1] != btgl_prev_r) wrote_r <= 1'b1;
      if (stop_seen && wrote_r) begin
        wr_busy_r <= 1'b1;
        wr_cnt_r <= 32'(WRITE_CYCLES - 1);
        wrote_r <= 1'b0;
      end else if (wr_busy_r) begin
        if (wr_cnt_r == 32'h0) wr_busy_r <= 1'b0;
        else wr_cnt_r <= wr_cnt_r - 32'h1;
      end
    end
  end

endmodule

// ---- testbench/eisb_front_chk.sv ----
// Purpose: Port assertions for the bus front end
// Assumes: Core clock domain only; bus pins sampled as levels
// Notes: Bound into every front end instance
`timescale 1ns/1ps
module eisb_front_chk #(
  parameter int POWERUP_CYCLES = 50,
  parameter int WRITE_CYCLES = 4000
) (
  input wire logic CORE_CLK_I,
  input wire logic RESETN_I,
  input wire logic CLK_EN_I,
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic READY_O,
  input wire logic WRITE_BUSY_O,
  input wire logic BYTE_STB_O,
  input wire logic FRAME_END_O
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  int up_r;   // Cycles since release, saturating
  int busy_r; // Length of current write cycle
  // Saturates so long runs never wrap
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      up_r <= 0;
    end else if (CLK_EN_I && up_r < POWERUP_CYCLES + 4) begin
      up_r <= up_r + 1;
    end
  end
  // Cleared whenever the timer is idle
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      busy_r <= 0;
    end else begin
      busy_r <= WRITE_BUSY_O ? busy_r + 1 : 0;
    end
  end
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  chk_ready_early: assert property (up_r < POWERUP_CYCLES - 2 |-> !READY_O)
    else $error("ready too early");
  chk_ready_late: assert property (up_r == POWERUP_CYCLES + 4 |-> READY_O)
    else $error("ready too late");
  chk_reset_quiet: assert property (disable iff (1'b0) !RESETN_I |->
    !READY_O && !SDA_OE_O && !WRITE_BUSY_O) else $error("outputs live in reset");
  chk_pull_only: assert property (SDA_O == 1'b0)
    else $error("data pin driven high");
  chk_oe_scl_low: assert property ($changed(SDA_OE_O) |-> !SCL_I)
    else $error("data changed while clock high");
  chk_ack_hold: assert property ($rose(SDA_OE_O) |=> SDA_OE_O [*8])
    else $error("pull released too soon");
  chk_unready_quiet: assert property (!READY_O |-> !SDA_OE_O)
    else $error("answer before ready");
  chk_busy_no_ack: assert property (WRITE_BUSY_O |-> !$rose(SDA_OE_O))
    else $error("answer during write cycle");
  chk_busy_len: assert property ($fell(WRITE_BUSY_O) |->
    busy_r >= WRITE_CYCLES - 2 && busy_r <= WRITE_CYCLES + 2) else $error("write length");
  chk_stop_pulse: assert property (FRAME_END_O |=> !FRAME_END_O)
    else $error("frame end not a pulse");
  chk_stop_release: assert property (FRAME_END_O |-> !SDA_OE_O)
    else $error("pulling at stop");
  cov_ack: cover property ($rose(SDA_OE_O));
  cov_byte: cover property (BYTE_STB_O);
  cov_write: cover property ($fell(WRITE_BUSY_O));
  cov_stop: cover property (FRAME_END_O);
endmodule
bind eisb_front eisb_front_chk #(.POWERUP_CYCLES(POWERUP_CYCLES),
  .WRITE_CYCLES(WRITE_CYCLES)) u_chk (.CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I),
  .CLK_EN_I(CLK_EN_I), .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .READY_O(READY_O), .WRITE_BUSY_O(WRITE_BUSY_O), .BYTE_STB_O(BYTE_STB_O),
  .FRAME_END_O(FRAME_END_O));

// ---- testbench/eisb_master_model.sv ----
// Purpose: Bus master model that clocks the serial bus
// Assumes: Open-drain wires resolved by the bench with pull-ups
// Notes: Clock halves of 1.2 us leave room for filter latency
`timescale 1ns/1ps
module eisb_master_model #(
  parameter int HP = 80 // Link cycles per clock half
) (
  input wire logic link_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o // Low pulls, high releases
);
  // Bus idles released; clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic half();
    repeat (HP) @(posedge link_clk_i);
  endtask
  task automatic start();
    @(posedge link_clk_i);
    sda_o <= 1'b0; // Data falls, clock high
    half();
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    @(posedge link_clk_i);
    sda_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_o <= 1'b1; // Data rises, clock high
    half(); // Bus free before next start
  endtask
  // Data moves a quarter into the low phase
  task automatic bit_io(input logic b, output logic r);
    repeat (HP / 4) @(posedge link_clk_i);
    sda_o <= b; // Zero pulls, one releases
    half();
    scl_o <= 1'b1; // Data held while high
    half();
    r = sda_i;
    scl_o <= 1'b0; // Only this side clocks
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, ack); // Released ninth clock
  endtask
  // Short data pulse of 90 ns, just under the 100 ns filter width
  task automatic glitch();
    @(posedge link_clk_i);
    sda_o <= 1'b0;
    repeat (6) @(posedge link_clk_i);
    sda_o <= 1'b1;
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// Purpose: Self-checking bench for the bus front end
// Assumes: Short power-up and write counts
// Notes: Bytes written are noted in a queue
`timescale 1ns/1ps
module tb_top;
  localparam int PU = 50;
  localparam int WR = 4000;
  logic CORE_CLK_I, link_clk, RESETN_I, CLK_EN_I, WP_I, RD_DATA_VALID_I;
  logic [2:0] ADDR_STRAP_I;
  logic [7:0] RD_DATA_I, BYTE_DATA_O;
  logic SDA_O, SDA_OE_O, READY_O, WRITE_BUSY_O, BYTE_STB_O, FRAME_END_O;
  wire scl_w;
  wire sda_m;
  wire sda_w = sda_m & (SDA_OE_O ? SDA_O : 1'b1); // Pull-up wire
  int failures = 0;
  int tests_run = 0;
  int frame_cnt = 0;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h39a63d04;
  eisb_front #(.POWERUP_CYCLES(PU), .WRITE_CYCLES(WR)) u_dut (.CORE_CLK_I(CORE_CLK_I),
    .RESETN_I(RESETN_I), .CLK_EN_I(CLK_EN_I), .SCL_I(scl_w), .SDA_I(sda_w),
    .ADDR_STRAP_I(ADDR_STRAP_I), .WP_I(WP_I), .RD_DATA_VALID_I(RD_DATA_VALID_I),
    .RD_DATA_I(RD_DATA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .READY_O(READY_O),
    .WRITE_BUSY_O(WRITE_BUSY_O), .BYTE_STB_O(BYTE_STB_O), .BYTE_DATA_O(BYTE_DATA_O),
    .FRAME_END_O(FRAME_END_O));
  eisb_master_model u_mst (.link_clk_i(link_clk), .sda_i(sda_w), .scl_o(scl_w),
    .sda_o(sda_m));
  // ----------------------------------------
  // Clocks, helpers
  // ----------------------------------------
  initial begin
    CORE_CLK_I = 1'b0;
    forever #5 CORE_CLK_I = ~CORE_CLK_I;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Address, then n random bytes; ack 0 means answered
  task automatic frame(input logic [7:0] adr, input logic ea, input int n, input logic ed);
    logic [7:0] q;
    logic a;
    u_mst.start();
    u_mst.xfer(adr, q, a);
    check("addr_ack", 8'(a), 8'(ea));
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      if (!ed) exp_q.push_back(seed[7:0]);
      u_mst.xfer(seed[7:0], q, a);
      check("data_ack", 8'(a), 8'(ed));
    end
  endtask
  task automatic wait_idle();
    int k = 0;
    while (WRITE_BUSY_O !== 1'b0 && k < 6000) begin
      @(negedge CORE_CLK_I);
      k++;
    end
    check("busy_done", 8'(WRITE_BUSY_O), 8'h0);
  endtask
  // Monitor off the launch edge, so pulses are settled
  always @(negedge CORE_CLK_I) begin
    if (FRAME_END_O === 1'b1) frame_cnt++;
    if (BYTE_STB_O === 1'b1) begin
      if (exp_q.size() == 0) check("stray_byte", 8'h1, 8'h0);
      else check("byte_data", BYTE_DATA_O, exp_q.pop_front());
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] q;
    logic a;
    logic [7:0] dev;
    int fc;
    RESETN_I = 1'b0;
    CLK_EN_I = 1'b1;
    WP_I = 1'b0;
    RD_DATA_VALID_I = 1'b0;
    ADDR_STRAP_I = 3'h0;
    RD_DATA_I = 8'h0;
    repeat (16) @(posedge CORE_CLK_I);
    seed = lfsr(seed);
    RESETN_I <= 1'b1;
    ADDR_STRAP_I <= seed[2:0]; // Random static strap
    RD_DATA_I <= seed[15:8];
    RD_DATA_VALID_I <= seed[16];
    @(negedge CORE_CLK_I);
    check("ready_early", 8'(READY_O), 8'h0);
    repeat (PU + 4) @(negedge CORE_CLK_I);
    check("ready", 8'(READY_O), 8'h1);
    dev = {4'ha, ADDR_STRAP_I, 1'b0};
    frame(dev, 1'b0, 2, 1'b0); // Back-to-back bytes
    u_mst.stop();
    check("frame_end", 8'(frame_cnt), 8'h1);
    check("busy", 8'(WRITE_BUSY_O), 8'h1);
    frame(dev, 1'b1, 0, 1'b0); // Polled mid write cycle
    u_mst.stop();
    wait_idle();
    for (int i = 0; i < 2; i++) begin // Wrong type, then wrong strap
      frame(i ? (dev ^ 8'h02) : (dev ^ 8'h10), 1'b1, 0, 1'b0);
      u_mst.stop();
    end
    @(posedge CORE_CLK_I);
    WP_I <= 1'b1;
    frame(dev, 1'b0, 1, 1'b1); // Protected first byte refused
    u_mst.stop();
    @(posedge CORE_CLK_I);
    WP_I <= 1'b0;
    wait_idle();
    frame(dev | 8'h01, 1'b0, 0, 1'b0);
    u_mst.xfer(8'hff, q, a);
    check("rd_data", q, RD_DATA_I);
    u_mst.stop();
    fc = frame_cnt;
    u_mst.glitch();
    repeat (100) @(negedge CORE_CLK_I);
    check("glitch", 8'(frame_cnt - fc), 8'h0);
    frame(dev, 1'b0, 0, 1'b0);
    @(posedge CORE_CLK_I);
    RESETN_I <= 1'b0;
    repeat (2) @(negedge CORE_CLK_I);
    check("in_reset", 8'({READY_O, SDA_OE_O, WRITE_BUSY_O}), 8'h0);
    @(posedge CORE_CLK_I);
    RESETN_I <= 1'b1;
    u_mst.stop();
    frame(dev, 1'b0, 1, 1'b0); // Recovers after brown-out
    u_mst.stop();
    check("queue_empty", 8'(exp_q.size()), 8'h0);
    wrap_up();
  end
  // Whole run needs about 37000 cycles
  initial begin
    repeat (90000) @(posedge CORE_CLK_I);
    failures++;
    wrap_up();
  end
endmodule
